// ==== rtl/sfs_status_bank.sv ====
// Thermal, device history and bus fault status registers behind a 16-bit SPI slave.
`timescale 1ns/1ps
// How it works
// - Thermal status bits 7:3 always read as zero.
// - Stage-2 thermal shutdown sets bit 2 and requests fail-safe mode.
// - Stage-1 thermal shutdown sets bit 1, readable and clearable.
// - Thermal pre-warning sets bit 0.
// - Thermal flags stay set until software clears them.
// - Device bits 7:6 record the state before the last restart.
// - Watchdog fail, stage-2 shutdown, regulator undervoltage, fail-safe wake write 01.
// - Stop-to-sleep request and sleep without wake source also write 01.
// - Sleep request with uncleared wake flags still records sleep code 10.
// - Watchdog counter at 3:2 counts failures; fail outputs at 01 or 10.
// - Counter clears on good trigger or watchdog stop not caused by failure.
// - In configurations 2 and 4 counter holds until a good trigger.
// - Configuration 0: first failure forces restart only, no fail output.
// - Invalid SPI command sets device bit 1; only SPI clear, power-on or soft reset resets it.
// - Device bit 0 sets whenever the fail output activates.
// - LIN field 6:5: none, shutdown, transmit dominant, bus dominant over 20ms.
// - CAN field 2:1: same codes, with configurable timeout limits.
// - CAN supply undervoltage sets bus bit 0 and disables the transmitter.
// - Power-on or soft reset zeroes all three registers.
// - Restart keeps device fields and forces bits 5:4 to zero.
// - Restart keeps bus fields and forces reserved bits to zero.
// - Access bit 0 reads only; access bit 1 clears the register.
// - Only the watchdog counter changes by itself; other bits clear by command.
module sfs_status_bank #(
  parameter int LIN_DOM_CYCLES = sfs_pkg::SFS_LIN_DOM_CYCLES,
  parameter int CAN_TXD_CYCLES = sfs_pkg::SFS_CAN_TXD_CYCLES,
  parameter int CAN_BUS_CYCLES = sfs_pkg::SFS_CAN_BUS_CYCLES
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic soft_reset_in,
  input wire logic restart_in,
  input wire logic spi_clk_in,
  input wire logic spi_cs_n_in,
  input wire logic spi_mosi_in,
  output logic spi_miso_out,
  output logic spi_miso_oe_out,
  input wire sfs_pkg::sfs_thermal_evt_s thermal_evt_in,
  input wire sfs_pkg::sfs_wd_evt_s wd_evt_in,
  input wire sfs_pkg::sfs_mode_evt_s mode_evt_in,
  input wire logic [2:0] config_sel_in,
  input wire logic fail_output_activate_in,
  input wire logic fail_output_release_in,
  input wire sfs_pkg::sfs_pin_lvl_s xcvr_lvl_in,
  input wire logic can_supply_uv_in,
  output logic fail_output_out,
  output logic fail_safe_req_out,
  output logic can_tx_disable_out,
  output logic [7:0] thermal_protection_status_out,
  output logic [7:0] device_history_status_out,
  output logic [7:0] bus_fault_status_out
);

  typedef enum logic [1:0] {
    SFS_SPI_IDLE = 2'b00,
    SFS_SPI_SHIFT = 2'b01,
    SFS_SPI_END = 2'b10
  } sfs_spi_state_e;

  // A change counts once the second and third stages agree.
  function automatic logic sfs_filter(input logic s2, input logic s3, input logic prev);
    sfs_filter = (s2 == s3) ? s3 : prev;
  endfunction

  // Dominant-time counter that saturates one past its limit.
  function automatic logic [sfs_pkg::SFS_TIMER_W-1:0] sfs_tick(
    input logic dom, input logic [sfs_pkg::SFS_TIMER_W-1:0] cnt,
    input logic [sfs_pkg::SFS_TIMER_W-1:0] lim);
    if (!dom) begin
      sfs_tick = '0;
    end else if (cnt > lim) begin
      sfs_tick = cnt;
    end else begin
      sfs_tick = cnt + 1'b1;
    end
  endfunction

  function automatic logic [7:0] sfs_clr_mask(input logic [6:0] addr, input logic hit);
    sfs_clr_mask = 8'h00;
    if (hit) begin
      case (addr)
        sfs_pkg::SFS_ADDR_THERMAL: sfs_clr_mask = sfs_pkg::SFS_THERMAL_CLR;
        sfs_pkg::SFS_ADDR_DEVICE: sfs_clr_mask = sfs_pkg::SFS_DEVICE_CLR;
        sfs_pkg::SFS_ADDR_BUS: sfs_clr_mask = sfs_pkg::SFS_BUS_CLR;
        default: sfs_clr_mask = 8'h00;
      endcase
    end
  endfunction

  localparam logic [sfs_pkg::SFS_TIMER_W-1:0] LIN_LIM = LIN_DOM_CYCLES[sfs_pkg::SFS_TIMER_W-1:0];
  localparam logic [sfs_pkg::SFS_TIMER_W-1:0] CTX_LIM = CAN_TXD_CYCLES[sfs_pkg::SFS_TIMER_W-1:0];
  localparam logic [sfs_pkg::SFS_TIMER_W-1:0] CBS_LIM = CAN_BUS_CYCLES[sfs_pkg::SFS_TIMER_W-1:0];

  logic [2:0] sclk_sync_reg;
  logic [2:0] csn_sync_reg;
  logic [2:0] mosi_sync_reg;
  logic sclk_reg;
  logic csn_reg;
  logic mosi_reg;
  logic sclk_next;
  logic csn_next;
  logic [5:0] pin_s1_reg;
  logic [5:0] pin_s2_reg;
  logic [5:0] pin_s3_reg;
  logic [5:0] pin_lvl_reg;
  logic [sfs_pkg::SFS_TIMER_W-1:0] lin_txd_cnt_reg;
  logic [sfs_pkg::SFS_TIMER_W-1:0] lin_bus_cnt_reg;
  logic [sfs_pkg::SFS_TIMER_W-1:0] can_txd_cnt_reg;
  logic [sfs_pkg::SFS_TIMER_W-1:0] can_bus_cnt_reg;
  sfs_spi_state_e spi_state_reg;
  logic [4:0] bit_cnt_reg;
  logic [7:0] cmd_reg;
  logic [7:0] tx_reg;
  logic clear_hit;
  logic spi_invalid;
  logic [7:0] clr_mask;
  logic [7:0] thermal_reg;
  logic [7:0] device_reg;
  logic [7:0] bus_reg;
  logic [7:0] read_data;
  logic [1:0] wd_cnt_reg;
  logic [1:0] wd_cnt_next;
  logic [1:0] wd_thresh;
  logic wd_hold;
  logic fail_act;
  logic [1:0] lin_code;
  logic [1:0] can_code;
  logic lin_evt;
  logic can_evt;

  assign sclk_next = sfs_filter(sclk_sync_reg[1], sclk_sync_reg[2], sclk_reg);
  assign csn_next = sfs_filter(csn_sync_reg[1], csn_sync_reg[2], csn_reg);

  // Pin synchronisers; stage 0 feeds only stage 1.
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sclk_sync_reg <= 3'h0;
      csn_sync_reg <= 3'h7;
      mosi_sync_reg <= 3'h0;
      sclk_reg <= 1'b0;
      csn_reg <= 1'b1;
      mosi_reg <= 1'b0;
    end else begin
      sclk_sync_reg <= {sclk_sync_reg[1:0], spi_clk_in};
      csn_sync_reg <= {csn_sync_reg[1:0], spi_cs_n_in};
      mosi_sync_reg <= {mosi_sync_reg[1:0], spi_mosi_in};
      sclk_reg <= sclk_next;
      csn_reg <= csn_next;
      mosi_reg <= sfs_filter(mosi_sync_reg[1], mosi_sync_reg[2], mosi_reg);
    end
  end

  // Transceiver level synchronisers and dominant timers.
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pin_s1_reg <= 6'h00;
      pin_s2_reg <= 6'h00;
      pin_s3_reg <= 6'h00;
      pin_lvl_reg <= 6'h00;
      lin_txd_cnt_reg <= '0;
      lin_bus_cnt_reg <= '0;
      can_txd_cnt_reg <= '0;
      can_bus_cnt_reg <= '0;
    end else begin
      pin_s1_reg <= xcvr_lvl_in;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
      for (int i = 0; i < 6; i++) begin
        pin_lvl_reg[i] <= sfs_filter(pin_s2_reg[i], pin_s3_reg[i], pin_lvl_reg[i]);
      end
      lin_txd_cnt_reg <= sfs_tick(pin_lvl_reg[4], lin_txd_cnt_reg, LIN_LIM);
      lin_bus_cnt_reg <= sfs_tick(pin_lvl_reg[3], lin_bus_cnt_reg, LIN_LIM);
      can_txd_cnt_reg <= sfs_tick(pin_lvl_reg[1], can_txd_cnt_reg, CTX_LIM);
      can_bus_cnt_reg <= sfs_tick(pin_lvl_reg[0], can_bus_cnt_reg, CBS_LIM);
    end
  end

  // LIN fault code, bus dominant first.
  always_comb begin
    lin_evt = 1'b1;
    if (lin_bus_cnt_reg == LIN_LIM) begin
      lin_code = sfs_pkg::SFS_XCVR_BUS_DOM;
    end else if (lin_txd_cnt_reg == LIN_LIM) begin
      lin_code = sfs_pkg::SFS_XCVR_TXD_DOM;
    end else if (pin_lvl_reg[5]) begin
      lin_code = sfs_pkg::SFS_XCVR_TSD;
    end else begin
      lin_code = sfs_pkg::SFS_XCVR_OK;
      lin_evt = 1'b0;
    end
  end

  // CAN fault code with parameter limits.
  always_comb begin
    can_evt = 1'b1;
    if (can_bus_cnt_reg == CBS_LIM) begin
      can_code = sfs_pkg::SFS_XCVR_BUS_DOM;
    end else if (can_txd_cnt_reg == CTX_LIM) begin
      can_code = sfs_pkg::SFS_XCVR_TXD_DOM;
    end else if (pin_lvl_reg[2]) begin
      can_code = sfs_pkg::SFS_XCVR_TSD;
    end else begin
      can_code = sfs_pkg::SFS_XCVR_OK;
      can_evt = 1'b0;
    end
  end

  always_comb begin
    case (cmd_reg[6:0])
      sfs_pkg::SFS_ADDR_THERMAL: read_data = thermal_reg;
      sfs_pkg::SFS_ADDR_DEVICE: read_data = device_reg;
      sfs_pkg::SFS_ADDR_BUS: read_data = bus_reg;
      default: read_data = 8'h00;
    endcase
  end

  // Frame capture, LSB first; the data byte returns the addressed register.
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      spi_state_reg <= SFS_SPI_IDLE;
      bit_cnt_reg <= 5'h00;
      cmd_reg <= 8'h00;
      tx_reg <= 8'h00;
      spi_miso_out <= 1'b0;
      spi_miso_oe_out <= 1'b0;
    end else begin
      spi_miso_oe_out <= ~csn_reg;
      case (spi_state_reg)
        SFS_SPI_IDLE: begin
          bit_cnt_reg <= 5'h00;
          spi_miso_out <= 1'b0;
          if (!csn_reg) begin
            spi_state_reg <= SFS_SPI_SHIFT;
          end
        end
        SFS_SPI_SHIFT: begin
          if (csn_reg) begin
            spi_state_reg <= SFS_SPI_END;
          end else if (sclk_next && !sclk_reg) begin
            if (bit_cnt_reg < sfs_pkg::SFS_ADDR_BYTE_BITS) begin
              cmd_reg <= {mosi_reg, cmd_reg[7:1]};
            end
            if (bit_cnt_reg != 5'h1F) begin
              bit_cnt_reg <= bit_cnt_reg + 5'h01;
            end
          end else if (!sclk_next && sclk_reg) begin
            if (bit_cnt_reg == sfs_pkg::SFS_ADDR_BYTE_BITS) begin
              spi_miso_out <= read_data[0];
              tx_reg <= {1'b0, read_data[7:1]};
            end else if (bit_cnt_reg > sfs_pkg::SFS_ADDR_BYTE_BITS) begin
              spi_miso_out <= tx_reg[0];
              tx_reg <= {1'b0, tx_reg[7:1]};
            end else begin
              spi_miso_out <= 1'b0;
            end
          end
        end
        SFS_SPI_END: begin
          spi_state_reg <= SFS_SPI_IDLE;
        end
        default: begin
          spi_state_reg <= SFS_SPI_IDLE;
        end
      endcase
    end
  end

  // Clear happens at frame end, only for a full frame with access bit set.
  assign clear_hit = (spi_state_reg == SFS_SPI_END) &&
    (bit_cnt_reg == sfs_pkg::SFS_FRAME_BITS) && cmd_reg[sfs_pkg::SFS_ACCESS_BIT];
  assign clr_mask = sfs_clr_mask(cmd_reg[6:0], clear_hit);
  // A frame of the wrong length is an invalid command.
  assign spi_invalid = (spi_state_reg == SFS_SPI_END) &&
    (bit_cnt_reg != sfs_pkg::SFS_FRAME_BITS);

  // Fail output threshold depends on the configuration.
  assign wd_thresh = (config_sel_in == sfs_pkg::SFS_CFG_2) ? sfs_pkg::SFS_WDCNT_ONE :
    sfs_pkg::SFS_WDCNT_TWO;
  // Configurations 2 and 4 keep a nonzero counter through a watchdog stop.
  assign wd_hold = ((config_sel_in == sfs_pkg::SFS_CFG_2) ||
    (config_sel_in == sfs_pkg::SFS_CFG_4)) && (wd_cnt_reg != sfs_pkg::SFS_WDCNT_ZERO);

  always_comb begin
    wd_cnt_next = wd_cnt_reg;
    fail_act = fail_output_activate_in;
    if (wd_evt_in.trigger_ok) begin
      wd_cnt_next = sfs_pkg::SFS_WDCNT_ZERO;
    end else if (wd_evt_in.fail) begin
      // Count up, never past the activation value.
      if (wd_cnt_reg < wd_thresh) begin
        wd_cnt_next = wd_cnt_reg + 2'h1;
      end
      // Configuration 0 shares the two-failure threshold, so the first is silent.
      if (wd_cnt_reg + 2'h1 == wd_thresh) begin
        fail_act = 1'b1;
      end
    end else if (wd_evt_in.stopped && !wd_evt_in.stop_by_fail && !wd_hold) begin
      // Stopped watchdog clears unless the stop came from a failure or wd_hold is set.
      wd_cnt_next = sfs_pkg::SFS_WDCNT_ZERO;
    end
  end

  // Power-on and soft reset zero the bank; restart keeps its fields.
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      thermal_reg <= sfs_pkg::SFS_RESET_VALUE;
    end else if (soft_reset_in) begin
      thermal_reg <= sfs_pkg::SFS_RESET_VALUE;
    end else begin
      // Flags stick; an event in a clear cycle wins.
      thermal_reg <= ((thermal_reg & sfs_pkg::SFS_THERMAL_KEEP) & ~clr_mask) |
        // Only bits 2:0 can ever be set.
        (8'(thermal_evt_in.stage2) << sfs_pkg::SFS_BIT_STAGE2) |
        (8'(thermal_evt_in.stage1) << sfs_pkg::SFS_BIT_STAGE1) |
        (8'(thermal_evt_in.prewarn) << sfs_pkg::SFS_BIT_PREWARN);
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      device_reg <= sfs_pkg::SFS_RESET_VALUE;
      wd_cnt_reg <= sfs_pkg::SFS_WDCNT_ZERO;
    end else if (soft_reset_in) begin
      device_reg <= sfs_pkg::SFS_RESET_VALUE;
      wd_cnt_reg <= sfs_pkg::SFS_WDCNT_ZERO;
    end else begin
      wd_cnt_reg <= wd_cnt_next;
      // Keep mask forces bits 5:4 to zero across a restart.
      // Software clears never touch the counter bits.
      device_reg <= (device_reg & sfs_pkg::SFS_DEVICE_KEEP) & ~clr_mask;
      device_reg[sfs_pkg::SFS_WDCNT_LSB +: 2] <= wd_cnt_next;
      // Illegal sleep requests count as failure.
      // Sleep entry with uncleared wake flags still records sleep.
      if (mode_evt_in.failure_restart || mode_evt_in.illegal_sleep) begin
        device_reg[sfs_pkg::SFS_PRIOR_LSB +: 2] <= sfs_pkg::SFS_PRIOR_FAILURE;
      end else if (mode_evt_in.sleep_entry) begin
        device_reg[sfs_pkg::SFS_PRIOR_LSB +: 2] <= sfs_pkg::SFS_PRIOR_SLEEP;
      end
      if (spi_invalid) begin
        device_reg[sfs_pkg::SFS_BIT_SPI_FAIL] <= 1'b1;
      end
      // Failure flag follows fail output activation.
      if (fail_act) begin
        device_reg[sfs_pkg::SFS_BIT_FAILURE] <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      bus_reg <= sfs_pkg::SFS_RESET_VALUE;
    end else if (soft_reset_in) begin
      bus_reg <= sfs_pkg::SFS_RESET_VALUE;
    end else begin
      // Keep mask zeroes reserved bits across a restart.
      bus_reg <= (bus_reg & sfs_pkg::SFS_BUS_KEEP) & ~clr_mask;
      if (lin_evt) begin
        bus_reg[sfs_pkg::SFS_LIN_LSB +: 2] <= lin_code;
      end
      if (can_evt) begin
        bus_reg[sfs_pkg::SFS_CAN_LSB +: 2] <= can_code;
      end
      if (can_supply_uv_in) begin
        bus_reg[sfs_pkg::SFS_BIT_CAN_UV] <= 1'b1;
      end
    end
  end

  // Fail output, fail-safe request and transmitter disable.
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      fail_output_out <= 1'b0;
      fail_safe_req_out <= 1'b0;
      can_tx_disable_out <= 1'b0;
    end else begin
      if (fail_act) begin
        fail_output_out <= 1'b1;
      end else if (fail_output_release_in || soft_reset_in) begin
        fail_output_out <= 1'b0;
      end
      fail_safe_req_out <= thermal_evt_in.stage2;
      // Transmitter stays off while the supply is low.
      can_tx_disable_out <= can_supply_uv_in;
    end
  end

  // Restart needs no own action: keep masks already hold reserved bits at zero.
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      thermal_protection_status_out <= sfs_pkg::SFS_RESET_VALUE;
      device_history_status_out <= sfs_pkg::SFS_RESET_VALUE;
      bus_fault_status_out <= sfs_pkg::SFS_RESET_VALUE;
    end else begin
      thermal_protection_status_out <= thermal_reg;
      device_history_status_out <= device_reg;
      bus_fault_status_out <= bus_reg | {7'h00, restart_in & 1'b0};
    end
  end

endmodule

// ==== shared/sfs_pkg.sv ====
// Shared constants and carrier types for the fault status register bank.
package sfs_pkg;

  // Register addresses (7-bit SPI address field).
  localparam logic [6:0] SFS_ADDR_THERMAL = 7'h42;
  localparam logic [6:0] SFS_ADDR_DEVICE = 7'h43;
  localparam logic [6:0] SFS_ADDR_BUS = 7'h44;

  localparam logic [7:0] SFS_RESET_VALUE = 8'h00;

  // Bits that survive a restart, and bits that software may clear.
  localparam logic [7:0] SFS_THERMAL_KEEP = 8'h07;
  localparam logic [7:0] SFS_DEVICE_KEEP = 8'hCF;
  localparam logic [7:0] SFS_BUS_KEEP = 8'h67;
  localparam logic [7:0] SFS_THERMAL_CLR = 8'h07;
  localparam logic [7:0] SFS_DEVICE_CLR = 8'hC3;
  localparam logic [7:0] SFS_BUS_CLR = 8'h67;

  // Field positions.
  localparam int SFS_BIT_STAGE2 = 2;
  localparam int SFS_BIT_STAGE1 = 1;
  localparam int SFS_BIT_PREWARN = 0;
  localparam int SFS_PRIOR_LSB = 6;
  localparam int SFS_WDCNT_LSB = 2;
  localparam int SFS_BIT_SPI_FAIL = 1;
  localparam int SFS_BIT_FAILURE = 0;
  localparam int SFS_LIN_LSB = 5;
  localparam int SFS_CAN_LSB = 1;
  localparam int SFS_BIT_CAN_UV = 0;

  // Prior-state codes.
  localparam logic [1:0] SFS_PRIOR_CLEARED = 2'h0;
  localparam logic [1:0] SFS_PRIOR_FAILURE = 2'h1;
  localparam logic [1:0] SFS_PRIOR_SLEEP = 2'h2;

  // Watchdog failure counter values.
  localparam logic [1:0] SFS_WDCNT_ZERO = 2'h0;
  localparam logic [1:0] SFS_WDCNT_ONE = 2'h1;
  localparam logic [1:0] SFS_WDCNT_TWO = 2'h2;

  // Configuration selector values.
  localparam logic [2:0] SFS_CFG_0 = 3'h0;
  localparam logic [2:0] SFS_CFG_2 = 3'h2;
  localparam logic [2:0] SFS_CFG_4 = 3'h4;

  // Transceiver failure codes.
  localparam logic [1:0] SFS_XCVR_OK = 2'h0;
  localparam logic [1:0] SFS_XCVR_TSD = 2'h1;
  localparam logic [1:0] SFS_XCVR_TXD_DOM = 2'h2;
  localparam logic [1:0] SFS_XCVR_BUS_DOM = 2'h3;

  // SPI frame layout.
  localparam logic [4:0] SFS_FRAME_BITS = 5'h10;
  localparam logic [4:0] SFS_ADDR_BYTE_BITS = 5'h08;
  localparam int SFS_ACCESS_BIT = 7;

  // Timing.
  localparam int SFS_CLK_MHZ = 125;
  localparam int SFS_LIN_DOM_TIME_MS = 20;
  localparam int SFS_LIN_DOM_CYCLES = SFS_LIN_DOM_TIME_MS * 1000 * SFS_CLK_MHZ;
  localparam int SFS_CAN_TXD_TIME_US = 1000;
  localparam int SFS_CAN_BUS_TIME_US = 1000;
  localparam int SFS_CAN_TXD_CYCLES = SFS_CAN_TXD_TIME_US * SFS_CLK_MHZ;
  localparam int SFS_CAN_BUS_CYCLES = SFS_CAN_BUS_TIME_US * SFS_CLK_MHZ;
  localparam int SFS_TIMER_W = 24;

  typedef struct packed {
    logic stage2;
    logic stage1;
    logic prewarn;
  } sfs_thermal_evt_s;

  typedef struct packed {
    logic fail;
    logic trigger_ok;
    logic stopped;
    logic stop_by_fail;
  } sfs_wd_evt_s;

  typedef struct packed {
    logic failure_restart;
    logic illegal_sleep;
    logic sleep_entry;
  } sfs_mode_evt_s;

  typedef struct packed {
    logic lin_tsd;
    logic lin_txd_dom;
    logic lin_bus_dom;
    logic can_tsd;
    logic can_txd_dom;
    logic can_bus_dom;
  } sfs_pin_lvl_s;

endpackage

// ==== verification/sfs_spi_master.sv ====
// SPI master model standing in for the microcontroller.
`timescale 1ns/1ps
module sfs_spi_master (
  input wire logic sys_clk_in,
  input wire logic spi_miso_in,
  input wire logic spi_miso_oe_in,
  output logic spi_clk_out,
  output logic spi_cs_n_out,
  output logic spi_mosi_out
);
  // Slow half periods leave room for the device's input synchronisers.
  localparam int HALF = 8;
  initial begin
    spi_clk_out = 1'b0;
    spi_cs_n_out = 1'b1;
    spi_mosi_out = 1'b0;
  end
  task automatic xfer(input logic [6:0] addr, input logic acc, input int nbits,
      output logic [7:0] rd);
    logic [15:0] frame;
    frame = {8'h00, acc, addr};
    rd = 8'h00;
    spi_cs_n_out = 1'b0;
    repeat (HALF) @(negedge sys_clk_in);
    for (int i = 0; i < nbits; i++) begin
      spi_mosi_out = frame[i];
      repeat (HALF) @(negedge sys_clk_in);
      spi_clk_out = 1'b1;
      repeat (HALF) @(negedge sys_clk_in);
      if (i >= 8) rd[i-8] = spi_miso_oe_in ? spi_miso_in : 1'bx;
      spi_clk_out = 1'b0;
    end
    repeat (HALF) @(negedge sys_clk_in);
    spi_cs_n_out = 1'b1;
    spi_mosi_out = ~spi_mosi_out;
    repeat (HALF) @(negedge sys_clk_in);
  endtask
endmodule

// ==== verification/sfs_status_bank_chk.sv ====
// Assertion checker for the fault status register bank.
`timescale 1ns/1ps
module sfs_status_bank_chk (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic soft_reset_in,
  input wire logic spi_cs_n_in,
  input wire sfs_pkg::sfs_thermal_evt_s thermal_evt_in,
  input wire logic fail_output_activate_in,
  input wire logic can_supply_uv_in,
  input wire logic fail_safe_req_out,
  input wire logic can_tx_disable_out,
  input wire logic [7:0] thermal_protection_status_out,
  input wire logic [7:0] device_history_status_out,
  input wire logic [7:0] bus_fault_status_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  // Cycles since a frame ended or a soft reset; a clear may only land shortly after one.
  logic [4:0] quiet_reg;
  logic cs_d_reg;
  logic [23:0] rc_bits;
  assign rc_bits = {thermal_protection_status_out & 8'h07,
    device_history_status_out & 8'hC3, bus_fault_status_out & 8'h67};
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cs_d_reg <= 1'b1;
      quiet_reg <= 5'h00;
    end else begin
      cs_d_reg <= spi_cs_n_in;
      if (soft_reset_in || (spi_cs_n_in && !cs_d_reg)) begin
        quiet_reg <= 5'h00;
      end else if (quiet_reg != 5'h1F) begin
        quiet_reg <= quiet_reg + 5'h01;
      end
    end
  end
  sequence s_set(ev);
    !soft_reset_in && ev ##1 !soft_reset_in;
  endsequence
  a_therm_rsvd_zero: assert property (thermal_protection_status_out[7:3] == 5'h00)
    else $error("thermal reserved bits set");
  a_stage2_flag: assert property (s_set(thermal_evt_in.stage2) |=>
    thermal_protection_status_out[2]) else $error("stage 2 flag missing");
  a_stage2_failsafe: assert property (thermal_evt_in.stage2 |=> fail_safe_req_out)
    else $error("fail-safe request missing");
  a_stage1_flag: assert property (s_set(thermal_evt_in.stage1) |=>
    thermal_protection_status_out[1]) else $error("stage 1 flag missing");
  a_prewarn_flag: assert property (s_set(thermal_evt_in.prewarn) |=>
    thermal_protection_status_out[0]) else $error("prewarning flag missing");
  a_flags_sticky: assert property ((|($past(rc_bits) & ~rc_bits)) |-> quiet_reg < 5'h10)
    else $error("status bit cleared without command");
  a_reserved_zero: assert property ((device_history_status_out & 8'h30) == 8'h00 &&
    (bus_fault_status_out & 8'h98) == 8'h00) else $error("reserved bits set");
  a_wdcnt_range: assert property (device_history_status_out[3:2] != 2'h3)
    else $error("watchdog counter reached 3");
  a_failure_set: assert property (s_set(fail_output_activate_in) |=>
    device_history_status_out[0]) else $error("failure bit missing");
  a_uv_disable: assert property (can_supply_uv_in |=> can_tx_disable_out)
    else $error("transmitter not disabled");
  a_uv_flag: assert property (s_set(can_supply_uv_in) |=> bus_fault_status_out[0])
    else $error("undervoltage flag missing");
endmodule
bind sfs_status_bank sfs_status_bank_chk sfs_status_bank_chk_inst (
  .sys_clk_in(sys_clk_in), .rst_in(rst_in), .soft_reset_in(soft_reset_in),
  .spi_cs_n_in(spi_cs_n_in), .thermal_evt_in(thermal_evt_in),
  .fail_output_activate_in(fail_output_activate_in), .can_supply_uv_in(can_supply_uv_in),
  .fail_safe_req_out(fail_safe_req_out), .can_tx_disable_out(can_tx_disable_out),
  .thermal_protection_status_out(thermal_protection_status_out),
  .device_history_status_out(device_history_status_out),
  .bus_fault_status_out(bus_fault_status_out)
);

// ==== verification/tb_top.sv ====
// Self-checking testbench for the fault status register bank.
`timescale 1ns/1ps
module tb_top;
  localparam int DOM = 20;
  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic soft_rst = 1'b0;
  logic restart = 1'b0;
  logic sclk, cs_n, mosi, miso, miso_oe, fo, fs_req, tx_dis;
  sfs_pkg::sfs_thermal_evt_s therm = '0;
  sfs_pkg::sfs_wd_evt_s wd = '0;
  sfs_pkg::sfs_mode_evt_s mode = '0;
  sfs_pkg::sfs_pin_lvl_s lvl = '0;
  logic [2:0] cfg = 3'h1;
  logic fo_on = 1'b0;
  logic fo_off = 1'b0;
  logic uv = 1'b0;
  logic [7:0] th_o, dv_o, bs_o, rd;
  int fail_count = 0;
  int checks_done = 0;
  always #4 sys_clk_in = ~sys_clk_in;
  sfs_status_bank #(.LIN_DOM_CYCLES(DOM), .CAN_TXD_CYCLES(DOM), .CAN_BUS_CYCLES(DOM))
      sfs_status_bank_inst (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .soft_reset_in(soft_rst),
    .restart_in(restart), .spi_clk_in(sclk), .spi_cs_n_in(cs_n), .spi_mosi_in(mosi),
    .spi_miso_out(miso), .spi_miso_oe_out(miso_oe), .thermal_evt_in(therm),
    .wd_evt_in(wd), .mode_evt_in(mode), .config_sel_in(cfg),
    .fail_output_activate_in(fo_on), .fail_output_release_in(fo_off), .xcvr_lvl_in(lvl),
    .can_supply_uv_in(uv), .fail_output_out(fo), .fail_safe_req_out(fs_req),
    .can_tx_disable_out(tx_dis), .thermal_protection_status_out(th_o),
    .device_history_status_out(dv_o), .bus_fault_status_out(bs_o));
  sfs_spi_master sfs_spi_master_inst (.sys_clk_in(sys_clk_in), .spi_miso_in(miso),
    .spi_miso_oe_in(miso_oe), .spi_clk_out(sclk), .spi_cs_n_out(cs_n), .spi_mosi_out(mosi));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk_in);
  endtask
  task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
    sfs_spi_master_inst.xfer(a, 1'b0, 16, rd);
    check(rd, exp);
  endtask
  task automatic clr(input logic [6:0] a);
    sfs_spi_master_inst.xfer(a, 1'b1, 16, rd);
    cyc(4);
  endtask
  // Pulses one event group for a single cycle and lets the status outputs settle.
  task automatic evt(input int k, input logic [3:0] v);
    case (k)
      0: therm = v[2:0];
      1: wd = v;
      2: mode = v[2:0];
      default: {fo_off, fo_on} = v[1:0];
    endcase
    cyc(1);
    {therm, wd, mode, fo_off, fo_on} = '0;
    cyc(3);
  endtask
  task automatic t_thermal();
    for (int i = 0; i < 3; i++) begin
      evt(0, 4'(1 << i));
      check(th_o, 8'(1 << i));
      clr(sfs_pkg::SFS_ADDR_THERMAL);
    end
    therm = 3'h7;
    cyc(1);
    therm = '0;
    check({7'h00, fs_req}, 8'h01);
    cyc(30);
    check(th_o, 8'h07);
    rd_chk(sfs_pkg::SFS_ADDR_THERMAL, 8'h07);
    rd_chk(7'h45, 8'h00);
    clr(sfs_pkg::SFS_ADDR_THERMAL);
    check(th_o, 8'h00);
    $display("thermal test done");
  endtask
  task automatic t_device();
    logic [2:0] codes [4] = '{3'h4, 3'h2, 3'h1, 3'h5};
    logic [7:0] exps [4] = '{8'h40, 8'h40, 8'h80, 8'h40};
    for (int i = 0; i < 4; i++) begin
      evt(2, {1'b0, codes[i]});
      check(dv_o, exps[i]);
      clr(sfs_pkg::SFS_ADDR_DEVICE);
    end
    for (int i = 0; i < 3; i++) begin
      evt(1, 4'h8);
      check(dv_o & 8'h0C, (i == 0) ? 8'h04 : 8'h08);
    end
    evt(1, 4'h4);
    check(dv_o & 8'h0C, 8'h00);
    cfg = 3'h2;
    evt(1, 4'h8);
    evt(1, 4'h2);
    check(dv_o & 8'h0C, 8'h04);
    evt(1, 4'h4);
    cfg = 3'h0;
    evt(3, 4'h2);
    clr(sfs_pkg::SFS_ADDR_DEVICE);
    evt(1, 4'h8);
    check({fo, dv_o[0]}, 8'h00);
    evt(1, 4'h4);
    evt(3, 4'h1);
    check({fo, dv_o[0]}, 8'h03);
    evt(3, 4'h2);
    clr(sfs_pkg::SFS_ADDR_DEVICE);
    check(dv_o, 8'h00);
    $display("device test done");
  endtask
  task automatic t_spi_fail();
    evt(2, 4'h1);
    sfs_spi_master_inst.xfer(sfs_pkg::SFS_ADDR_DEVICE, 1'b0, 15, rd);
    cyc(4);
    restart = 1'b1;
    cyc(1);
    restart = 1'b0;
    cyc(3);
    check(dv_o, 8'h82);
    rd_chk(sfs_pkg::SFS_ADDR_DEVICE, 8'h82);
    clr(sfs_pkg::SFS_ADDR_DEVICE);
    check(dv_o, 8'h00);
    $display("spi fail test done");
  endtask
  task automatic t_bus();
    lvl = 6'b001010;
    uv = 1'b1;
    cyc(DOM + 12);
    check({7'h00, tx_dis}, 8'h01);
    check(bs_o, 8'h65);
    lvl = '0;
    uv = 1'b0;
    restart = 1'b1;
    cyc(1);
    restart = 1'b0;
    cyc(6);
    check(bs_o, 8'h65);
    clr(sfs_pkg::SFS_ADDR_BUS);
    lvl = 6'b100100;
    cyc(8);
    lvl = '0;
    check(bs_o, 8'h22);
    clr(sfs_pkg::SFS_ADDR_BUS);
    lvl = 6'b010001;
    cyc(DOM + 12);
    lvl = '0;
    check(bs_o, 8'h46);
    evt(0, 4'h7);
    soft_rst = 1'b1;
    cyc(1);
    soft_rst = 1'b0;
    cyc(3);
    check(th_o | dv_o | bs_o, 8'h00);
    $display("bus and soft reset test done");
  endtask
  initial begin
    cyc(6);
    rst_in = 1'b0;
    cyc(4);
    check(th_o | dv_o | bs_o, 8'h00);
    t_thermal();
    t_device();
    t_spi_fail();
    t_bus();
    end_sim();
  end
  initial begin
    #400000;
    fail_count++;
    $display("watchdog expired");
    end_sim();
  end
endmodule
